//--- rtl/burst_sram_params.svh
`ifndef BURST_SRAM_PARAMS_SVH
`define BURST_SRAM_PARAMS_SVH

// ----------------------------------------------------------------
// Data bus organisation
// ----------------------------------------------------------------
`define SRAM_LANES      4
`define SRAM_LANE_W     8
`define SRAM_DATA_W     32

// ----------------------------------------------------------------
// Core size and burst counter
// ----------------------------------------------------------------
`define SRAM_ADDR_W     10
`define SRAM_DEPTH      1024
`define SRAM_BURST_W    2

// ----------------------------------------------------------------
// Burst order strap levels
// ----------------------------------------------------------------
`define ORDER_LINEAR      1'b0
`define ORDER_INTERLEAVED 1'b1

// ----------------------------------------------------------------
// Read data tap
// ----------------------------------------------------------------
`define TAP_DEPTH       16

`endif

//--- rtl/burst_sram_pkg.sv
package burst_sram_pkg;

    // ------------------------------------------------------------
    // Kind of cycle decoded from the registered inputs
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE,
        ACC_DESELECT
    } access_t;

    typedef logic [3:0] lane_mask_t;

endpackage

//--- rtl/tap_fifo.sv
`timescale 1ns/100ps

module tap_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    wire              push;
    wire              pop;

    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_in_ready  = (count != (PW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = store[rd_ptr];

    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
            if (push && !pop) begin
                count <= count + (PW+1)'(1);
            end else if (pop && !push) begin
                count <= count - (PW+1)'(1);
            end
        end
    end

endmodule

//--- rtl/burst_counter.sv
`timescale 1ns/100ps
`include "burst_sram_params.svh"

module burst_counter (
    input  wire logic                     i_clk,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_load,
    input  wire logic [`SRAM_BURST_W-1:0] i_start,
    input  wire logic                     i_step,
    input  wire logic                     i_interleave,
    output logic      [`SRAM_BURST_W-1:0] o_addr,
    output logic      [`SRAM_BURST_W-1:0] o_next
);

    logic [`SRAM_BURST_W-1:0] start_val;
    logic [`SRAM_BURST_W-1:0] step_cnt;
    wire  [`SRAM_BURST_W-1:0] next_cnt;

    // Wraps from the fourth beat back to the first
    assign next_cnt = step_cnt + `SRAM_BURST_W'(1);

    // ------------------------------------------------------------
    // Beat to address, XOR for interleaved, modulo add for linear
    // ------------------------------------------------------------
    assign o_addr = i_interleave ? (start_val ^ step_cnt)
                                 : (start_val + step_cnt);
    assign o_next = i_interleave ? (start_val ^ next_cnt)
                                 : (start_val + next_cnt);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            start_val <= '0;
            step_cnt  <= '0;
        end else if (i_load) begin
            start_val <= i_start;
            step_cnt  <= '0;
        end else if (i_step) begin
            step_cnt  <= next_cnt;
        end
    end

endmodule

//--- rtl/burst_sram.sv
`timescale 1ns/100ps
`include "burst_sram_params.svh"

module burst_sram (
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic [`SRAM_ADDR_W-1:0] i_addr,
    input  wire logic [`SRAM_DATA_W-1:0] i_dq,
    output logic      [`SRAM_DATA_W-1:0] o_dq,
    output logic                         o_dq_oe,
    input  wire logic                    i_output_enable_n,
    input  wire logic                    i_processor_addr_strobe_n,
    input  wire logic                    i_controller_addr_strobe_n,
    input  wire logic                    i_burst_step_n,
    input  wire logic                    i_global_write_n,
    input  wire logic                    i_byte_write_enable_n,
    input  wire logic [`SRAM_LANES-1:0]  i_byte_lane_select_n,
    input  wire logic                    i_chip_select_primary_n,
    input  wire logic                    i_chip_select_high,
    input  wire logic                    i_chip_select_extra_n,
    input  wire logic                    i_burst_order,
    output logic                         o_tap_valid,
    output logic      [`SRAM_DATA_W-1:0] o_tap_data,
    input  wire logic                    i_tap_ready,
    output logic                         o_tap_space
);

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    logic [`SRAM_ADDR_W-1:0] r_addr;
    logic [`SRAM_DATA_W-1:0] r_din;
    logic                    r_proc_strobe_n;
    logic                    r_ctrl_strobe_n;
    logic                    r_step_n;
    logic                    r_global_wr_n;
    logic                    r_byte_wr_en_n;
    logic [`SRAM_LANES-1:0]  r_lane_n;
    logic                    r_sel_primary_n;
    logic                    r_sel_high;
    logic                    r_sel_extra_n;
    logic                    r_order;

    // ------------------------------------------------------------
    // Access state
    // ------------------------------------------------------------
    logic                                  active;
    logic [`SRAM_ADDR_W-1:`SRAM_BURST_W]   base_hi;
    logic [`SRAM_DATA_W-1:0]               dout;
    logic                                  drive;

    // ------------------------------------------------------------
    // Decode wires
    // ------------------------------------------------------------
    wire                           selected;
    wire                           proc_taken;
    wire                           ctrl_taken;
    wire                           start;
    wire                           write_ctl;
    wire                           ctrl_write;
    wire                           step;
    wire                           load;
    wire                           interleave;
    wire                           is_read;
    wire                           is_write;
    wire [`SRAM_BURST_W-1:0]       burst_cur;
    wire [`SRAM_BURST_W-1:0]       burst_nxt;
    wire [`SRAM_BURST_W-1:0]       burst_used;
    wire [`SRAM_ADDR_W-1:0]        core_addr;
    wire [`SRAM_DATA_W-1:0]        rd_word;
    wire [`SRAM_DATA_W-1:0]        tap_out_data;
    wire                           tap_out_valid;
    wire                           tap_in_ready;
    burst_sram_pkg::lane_mask_t    lane_we;
    burst_sram_pkg::access_t       acc_kind;

    // Strap is re-sampled each clock; it is meant to stay static
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r_order <= `ORDER_INTERLEAVED;
        end else begin
            r_order <= i_burst_order;
        end
    end

    // Strobes reset to idle so no phantom access follows reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r_proc_strobe_n <= 1'b1;
            r_ctrl_strobe_n <= 1'b1;
            r_step_n        <= 1'b1;
            r_global_wr_n   <= 1'b1;
            r_byte_wr_en_n  <= 1'b1;
            r_lane_n        <= '1;
            r_sel_primary_n <= 1'b1;
            r_sel_high      <= 1'b0;
            r_sel_extra_n   <= 1'b1;
        end else begin
            r_proc_strobe_n <= i_processor_addr_strobe_n;
            r_ctrl_strobe_n <= i_controller_addr_strobe_n;
            r_step_n        <= i_burst_step_n;
            r_global_wr_n   <= i_global_write_n;
            r_byte_wr_en_n  <= i_byte_write_enable_n;
            r_lane_n        <= i_byte_lane_select_n;
            r_sel_primary_n <= i_chip_select_primary_n;
            r_sel_high      <= i_chip_select_high;
            r_sel_extra_n   <= i_chip_select_extra_n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r_addr <= '0;
            r_din  <= '0;
        end else begin
            r_addr <= i_addr;
            r_din  <= i_dq;
        end
    end

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    assign selected   = !r_sel_primary_n && r_sel_high && !r_sel_extra_n;
    assign proc_taken = !r_proc_strobe_n && !r_sel_primary_n;
    assign ctrl_taken = !r_ctrl_strobe_n;
    assign start      = proc_taken || ctrl_taken;
    assign write_ctl  = !r_global_wr_n
                     || (!r_byte_wr_en_n && (r_lane_n != '1));
    assign ctrl_write = ctrl_taken && !proc_taken
                     && selected && write_ctl;
    assign interleave = (r_order == `ORDER_INTERLEAVED);

    // Processor strobe opens as a read when selected; writes land later
    always_comb begin
        if (start && !selected) begin
            acc_kind = burst_sram_pkg::ACC_DESELECT;
        end else if (start) begin
            acc_kind = ctrl_write ? burst_sram_pkg::ACC_WRITE
                                  : burst_sram_pkg::ACC_READ;
        end else if (active) begin
            acc_kind = write_ctl ? burst_sram_pkg::ACC_WRITE
                                 : burst_sram_pkg::ACC_READ;
        end else begin
            acc_kind = burst_sram_pkg::ACC_IDLE;
        end
    end

    assign is_read  = (acc_kind == burst_sram_pkg::ACC_READ);
    assign is_write = (acc_kind == burst_sram_pkg::ACC_WRITE);

    // ------------------------------------------------------------
    // Address path
    // ------------------------------------------------------------
    // Advance is only looked at outside start cycles
    assign load       = start && selected;
    assign step       = !start && active && !r_step_n;
    assign burst_used = start ? r_addr[`SRAM_BURST_W-1:0]
                      : (step ? burst_nxt : burst_cur);
    assign core_addr  = start ? r_addr
                      : {base_hi, burst_used};

    burst_counter u_burst (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_load       (load),
        .i_start      (r_addr[`SRAM_BURST_W-1:0]),
        .i_step       (step),
        .i_interleave (interleave),
        .o_addr       (burst_cur),
        .o_next       (burst_nxt)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            active  <= 1'b0;
            base_hi <= '0;
        end else if (start) begin
            active  <= selected;
            if (selected) begin
                base_hi <= r_addr[`SRAM_ADDR_W-1:`SRAM_BURST_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Byte lanes and storage
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SRAM_LANES; g++) begin : g_lane
            logic [`SRAM_LANE_W-1:0] lane_mem [`SRAM_DEPTH];

            // Global write overrides the per-lane selects
            assign lane_we[g] = is_write
                             && (!r_global_wr_n
                             || (!r_byte_wr_en_n && !r_lane_n[g]));
            assign rd_word[g*`SRAM_LANE_W +: `SRAM_LANE_W] =
                lane_mem[core_addr];

            always_ff @(posedge i_clk) begin
                if (lane_we[g]) begin
                    lane_mem[core_addr] <=
                        r_din[g*`SRAM_LANE_W +: `SRAM_LANE_W];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output register and drive control
    // ------------------------------------------------------------
    // Drive follows the decoded cycle one clock later, which both
    // keeps the first cycle after deselect quiet and holds the bus
    // one extra cycle after a deselect for depth expansion.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            dout  <= '0;
            drive <= 1'b0;
        end else begin
            drive <= is_read;
            if (is_read) begin
                dout <= rd_word;
            end
        end
    end

    assign o_dq = dout;

    // Output enable is used unregistered so bus turnaround stays
    // under the master's direct control
    assign o_dq_oe = drive && !i_output_enable_n
                  && !is_write;

    // ------------------------------------------------------------
    // Read data tap
    // ------------------------------------------------------------
    // Reads never stall; a full tap drops beats, seen on o_tap_space
    tap_fifo #(
        .WIDTH (`SRAM_DATA_W),
        .DEPTH (`TAP_DEPTH)
    ) u_tap (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (is_read),
        .i_in_data   (rd_word),
        .o_in_ready  (tap_in_ready),
        .o_out_valid (tap_out_valid),
        .o_out_data  (tap_out_data),
        .i_out_ready (i_tap_ready)
    );

    assign o_tap_valid = tap_out_valid;
    assign o_tap_data  = tap_out_data;
    assign o_tap_space = tap_in_ready;

endmodule

//--- sim/dq_master_model.sv
`timescale 1ns/100ps
`include "burst_sram_params.svh"

module dq_master_model (
    input  wire logic                    i_clk,
    input  wire logic                    i_dev_oe,
    input  wire logic [`SRAM_DATA_W-1:0] i_dev_dq,
    input  wire logic                    i_drive,
    input  wire logic [`SRAM_DATA_W-1:0] i_data,
    output logic      [`SRAM_DATA_W-1:0] o_wire,
    output logic                         o_clash
);
    logic [`SRAM_DATA_W-1:0] last;

    // Released bus toggles each cycle so stale data never passes
    assign o_wire  = i_dev_oe ? i_dev_dq : (i_drive ? i_data : ~last);
    // Master drives only after output enable has released the part
    assign o_clash = i_dev_oe && i_drive;

    always_ff @(posedge i_clk) begin
        last <= o_wire;
    end
endmodule

//--- sim/burst_sram_asserts.sv
`timescale 1ns/100ps

module burst_sram_asserts (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       o_dq_oe,
    input wire logic       i_output_enable_n,
    input wire logic       i_processor_addr_strobe_n,
    input wire logic       i_controller_addr_strobe_n,
    input wire logic       i_global_write_n,
    input wire logic       i_byte_write_enable_n,
    input wire logic [3:0] i_byte_lane_select_n,
    input wire logic       i_chip_select_primary_n,
    input wire logic       i_chip_select_high,
    input wire logic       i_chip_select_extra_n,
    input wire logic       o_tap_valid,
    input wire logic       i_tap_ready,
    input wire logic       o_tap_space
);
    wire sel  = !i_chip_select_primary_n && i_chip_select_high &&
                !i_chip_select_extra_n;
    wire wctl = !i_global_write_n ||
                (!i_byte_write_enable_n && !(&i_byte_lane_select_n));
    wire pgo  = !i_processor_addr_strobe_n && !i_chip_select_primary_n;
    wire cgo  = !i_controller_addr_strobe_n;
    wire nost = i_processor_addr_strobe_n && i_controller_addr_strobe_n;
    wire rd   = sel && (pgo || (cgo && !wctl));
    wire dsl  = !sel && (pgo || cgo);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_rd_desel;
        rd ##1 (dsl && !i_output_enable_n);
    endsequence
    sequence s_proc_wr;
        (pgo && sel) ##1 (nost && wctl);
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0)
        i_sys_rst |=> !o_dq_oe && !o_tap_valid && o_tap_space)
        else $error("outputs active after reset");
    a_oe_gate: assert property (o_dq_oe |-> !i_output_enable_n)
        else $error("driving while output enable high");
    a_read_drive: assert property (rd ##1 !wctl |=>
        o_dq_oe == !i_output_enable_n)
        else $error("read data not driven");
    a_first_off: assert property (dsl ##1 rd |=> !o_dq_oe)
        else $error("driving in first cycle after deselect");
    a_double_desel: assert property (s_rd_desel |=>
        (o_dq_oe == !i_output_enable_n) ##1 !o_dq_oe)
        else $error("deselect release timing wrong");
    a_ctrl_wr_off: assert property (
        (cgo && i_processor_addr_strobe_n && sel && wctl) |=> !o_dq_oe)
        else $error("driving during controller write");
    a_proc_wr_off: assert property (s_proc_wr |=> !o_dq_oe)
        else $error("driving during processor write");
    a_tap_fills: assert property (rd && o_tap_space |-> ##2 o_tap_valid)
        else $error("read word missing from tap");
    a_full_holds: assert property (!o_tap_space && !i_tap_ready |=>
        !o_tap_space && o_tap_valid)
        else $error("full tap lost words");
endmodule

bind burst_sram burst_sram_asserts burst_sram_asserts_inst (
    .i_clk, .i_sys_rst, .o_dq_oe, .i_output_enable_n,
    .i_processor_addr_strobe_n, .i_controller_addr_strobe_n,
    .i_global_write_n, .i_byte_write_enable_n, .i_byte_lane_select_n,
    .i_chip_select_primary_n, .i_chip_select_high, .i_chip_select_extra_n,
    .o_tap_valid, .i_tap_ready, .o_tap_space
);

//--- sim/burst_sram_test.sv
`timescale 1ns/100ps
`include "burst_sram_params.svh"

module burst_sram_test;
    logic        i_clk, i_sys_rst, o_dq_oe, i_output_enable_n;
    logic [9:0]  i_addr;
    logic [31:0] i_dq, o_dq, o_tap_data, wdata;
    logic        i_processor_addr_strobe_n, i_controller_addr_strobe_n;
    logic        i_burst_step_n, i_global_write_n, i_byte_write_enable_n;
    logic [3:0]  i_byte_lane_select_n;
    logic        i_chip_select_primary_n, i_chip_select_high;
    logic        i_chip_select_extra_n, i_burst_order, wdrive, clash;
    logic        o_tap_valid, i_tap_ready, o_tap_space;
    logic [31:0] mem [0:`SRAM_DEPTH-1];
    logic [31:0] tapq [$];
    int          n_mismatch, check_count;

    burst_sram burst_sram_inst (
        .i_clk, .i_sys_rst, .i_addr, .i_dq, .o_dq, .o_dq_oe,
        .i_output_enable_n, .i_processor_addr_strobe_n,
        .i_controller_addr_strobe_n, .i_burst_step_n, .i_global_write_n,
        .i_byte_write_enable_n, .i_byte_lane_select_n,
        .i_chip_select_primary_n, .i_chip_select_high,
        .i_chip_select_extra_n, .i_burst_order, .o_tap_valid,
        .o_tap_data, .i_tap_ready, .o_tap_space
    );
    dq_master_model dq_master_model_inst (
        .i_clk, .i_dev_oe(o_dq_oe), .i_dev_dq(o_dq), .i_drive(wdrive),
        .i_data(wdata), .o_wire(i_dq), .o_clash(clash)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // Compare and pin tasks
    // ------------------------------------------------------------
    task automatic cmp_word(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic drv(input logic p, c, v, g, b, input logic [3:0] l,
                       input logic [9:0] a, input logic [31:0] d,
                       input logic s);
        @(negedge i_clk);
        i_processor_addr_strobe_n = p;
        i_controller_addr_strobe_n = c;
        i_burst_step_n = v;
        i_global_write_n = g;
        i_byte_write_enable_n = b;
        i_byte_lane_select_n = l;
        i_addr = a;
        wdata = d;
        i_chip_select_high = s;
        wdrive = !g || (!b && l != 4'hf);
    endtask
    task automatic desel;
        drv(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 10'h000, 32'h0, 1'b0);
    endtask
    task automatic wr(input logic p, input logic [9:0] a, input logic g, b,
                      input logic [3:0] l, input logic [31:0] d);
        if (p) begin
            drv(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, a, ~d, 1'b1);
            drv(1'b1, 1'b1, 1'b1, g, b, l, a, d, 1'b1);
        end else begin
            drv(1'b1, 1'b0, 1'b0, g, b, l, a, d, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            if (!g || (!b && !l[i])) mem[a][8*i +: 8] = d[8*i +: 8];
        end
        @(posedge i_clk);
        #1 cmp_bit(o_dq_oe, 1'b0);
        desel();
    endtask
    task automatic rburst(input logic ctl, input logic [9:0] a, input int n);
        logic [9:0] x;
        drv(ctl, !ctl, 1'b1, 1'b1, 1'b1, 4'hf, a, 32'h0, 1'b1);
        @(posedge i_clk);
        #1 cmp_bit(o_dq_oe, 1'b0);
        for (int k = 0; k < n; k++) begin
            x = {a[9:2], i_burst_order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
            if (k < n - 1)
                drv(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, a, 32'h0, 1'b1);
            else
                desel();
            @(posedge i_clk);
            #1 cmp_word(o_dq, mem[x]);
            cmp_bit(o_dq_oe, !i_output_enable_n);
            tapq.push_back(mem[x]);
        end
        @(posedge i_clk);
        #1 cmp_bit(o_dq_oe, 1'b0);
    endtask

    always @(posedge i_clk) begin
        #3;
        if (!i_sys_rst) cmp_bit(clash, 1'b0);
    end

    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end

    initial begin
        n_mismatch = 0;
        check_count = 0;
        i_sys_rst = 1'b1;
        i_addr = 10'h000;
        wdata = 32'h0;
        wdrive = 1'b0;
        i_output_enable_n = 1'b0;
        i_processor_addr_strobe_n = 1'b1;
        i_controller_addr_strobe_n = 1'b1;
        i_burst_step_n = 1'b1;
        i_global_write_n = 1'b1;
        i_byte_write_enable_n = 1'b1;
        i_byte_lane_select_n = 4'hf;
        i_chip_select_primary_n = 1'b0;
        i_chip_select_high = 1'b1;
        i_chip_select_extra_n = 1'b0;
        i_burst_order = 1'b1;
        i_tap_ready = 1'b1;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        cmp_bit(o_dq_oe, 1'b0);
        cmp_bit(o_tap_valid, 1'b0);
        cmp_bit(o_tap_space, 1'b1);
        // Read straight into a write: bus must stay released
        drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h020, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++)
            wr(1'b0, 10'(32 + i), 1'b0, 1'b0, 4'h5, 32'h0a1b2c30 + i);
        rburst(1'b0, 10'h021, 4);
        rburst(1'b1, 10'h022, 1);
        @(negedge i_clk);
        i_burst_order = 1'b0;
        rburst(1'b1, 10'h023, 4);
        wr(1'b0, 10'h022, 1'b1, 1'b0, 4'ha, 32'hffeeddcc);
        rburst(1'b0, 10'h022, 1);
        @(negedge i_clk);
        i_output_enable_n = 1'b1;
        wr(1'b1, 10'h021, 1'b1, 1'b0, 4'h3, 32'h99887766);
        rburst(1'b0, 10'h021, 2);
        drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h021, 32'h0, 1'b1);
        desel();
        @(negedge i_clk);
        cmp_bit(o_dq_oe, 1'b0);
        i_output_enable_n = 1'b0;
        #1 cmp_bit(o_dq_oe, 1'b1);
        // Ignored strobe mid-burst must act as a plain advance
        drv(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 10'h020, 32'h0, 1'b1);
        drv(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, 10'h023, 32'h0, 1'b1);
        i_chip_select_primary_n = 1'b1;
        desel();
        i_chip_select_primary_n = 1'b0;
        @(posedge i_clk);
        #1 cmp_word(o_dq, mem[10'h021]);
        cmp_bit(o_dq_oe, 1'b1);
        repeat (2) @(negedge i_clk);
        // Fill the tap while its reader stalls, then drain it
        i_tap_ready = 1'b0;
        tapq.delete();
        for (int i = 0; i < 5; i++)
            rburst(1'b0, 10'(32 + i % 4), 4);
        cmp_bit(o_tap_space, 1'b0);
        for (int i = 0; i < 16; i++) begin
            @(negedge i_clk);
            cmp_bit(o_tap_valid, 1'b1);
            cmp_word(o_tap_data, tapq[i]);
            i_tap_ready = 1'b1;
            @(negedge i_clk);
            i_tap_ready = 1'b0;
        end
        cmp_bit(o_tap_valid, 1'b0);
        conclude();
    end
endmodule
